//--- core/wdg_guarded_ctrl.sv
// Guarded watchdog control and status with APB register access and one interrupt.
// Assumes an APB3 master on clk_sys_in and a reset pin that is asynchronous.
// What this block does
// - Counter advances only while run bit set
// - Run set by guarded permitted write, reset
// - Run cleared by guarded permitted write
// - Flag writes need guard zero; guard reads one
// - Overflow pulses internal reset, sets flag
// - Permitted guarded zero write clears flag
// - Reset pin clears flag; watchdog reset not
// - Run and flag writes need control permit
// - Run writes need guard zero; reads one
// - Counter writes need counter permit bit
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "wdg_cfg.svh"
module wdg_guarded_ctrl import wdg_pkg::*; #(
  parameter int WDG_W = 8,
  parameter int PRESCALE = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ext_reset_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic wdg_reset_out,
  output logic irq_out
);
  localparam int RST_CYC = `WDG_RST_PULSE_CYC;
  localparam int RC_W = $clog2(RST_CYC + 1);

  if (RST_CYC < 1) begin : g_bad_pulse
    $error("wdg_guarded_ctrl: reset pulse must last a cycle");
  end

  function automatic logic guard_open(input logic [31:0] data, input int guard_bit);
    guard_open = !data[guard_bit];
  endfunction

  logic count_run;
  logic control_write_permit;
  logic counter_write_permit;
  logic overflow_reset_flag;
  logic [`WDG_IRQ_W-1:0] irq_stat;
  logic [`WDG_IRQ_W-1:0] irq_mask;
  logic [WDG_W-1:0] watchdog_counter;
  logic wrap;
  logic pin_sync_b;
  wdg_rst_state_t state;
  wdg_rst_state_t next_state;
  logic [RC_W-1:0] rst_cnt;
  logic [RC_W-1:0] next_rst_cnt;

  // Address decode
  wire [`WDG_ADDR_W-1:0] ofs = paddr_in[`WDG_ADDR_W-1:0];
  wire in_window = (paddr_in[31:`WDG_ADDR_W] == '0);
  wire sel_ctrl = in_window && (ofs == `WDG_OFS_CTRL);
  wire sel_count = in_window && (ofs == `WDG_OFS_COUNT);
  wire sel_stat = in_window && (ofs == `WDG_OFS_IRQ_STAT);
  wire sel_mask = in_window && (ofs == `WDG_OFS_IRQ_MASK);
  wire mapped = sel_ctrl || sel_count || sel_stat || sel_mask;
  wire setup = psel_in && !penable_in;
  wire access = psel_in && penable_in;
  wire wr = access && pwrite_in && mapped;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_count = wr && sel_count;

  // Reset pin and internal watchdog reset both reinitialise control
  wire pin_rst = !pin_sync_b;
  wire wdg_rst_active = (state == WDG_ST_RESET);
  wire sys_init = pin_rst || wdg_rst_active;

  // control permit gates run and flag
  wire ctrl_ok = wr_ctrl && control_write_permit;
  wire run_wr = ctrl_ok && guard_open(pwdata_in, `WDG_BIT_RUN_GUARD);
  wire flag_wr = ctrl_ok && guard_open(pwdata_in, `WDG_BIT_FLAG_GUARD);
  // clear on zero to flag and guard
  wire flag_clr = flag_wr && !pwdata_in[`WDG_BIT_FLAG];
  wire cperm_wr = wr_ctrl && guard_open(pwdata_in, `WDG_BIT_CPERMIT_GUARD);
  wire nperm_wr = wr_ctrl && guard_open(pwdata_in, `WDG_BIT_NPERMIT_GUARD);
  wire cnt_load = wr_count && counter_write_permit && !sys_init;

  wire [7:0] ctrl_view = {1'b1, counter_write_permit, 1'b1, control_write_permit,
                          1'b1, count_run, 1'b1, overflow_reset_flag};
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_view} :
                       sel_count ? {{(32 - WDG_W){1'b0}}, watchdog_counter} :
                       sel_stat ? {{(32 - `WDG_IRQ_W){1'b0}}, irq_stat} :
                       sel_mask ? {{(32 - `WDG_IRQ_W){1'b0}}, irq_mask} : 32'h00000000;

  assign pready_out = access;
  assign pslverr_out = access && !mapped;
  assign irq_out = |(irq_stat & irq_mask);
  assign wdg_reset_out = wdg_rst_active;

  wdg_sync2 #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(ext_reset_b_in),
    .sync_out(pin_sync_b)
  );

  wdg_counter #(.WDG_W(WDG_W), .PRESCALE(PRESCALE)) u_counter (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .hold_in(sys_init),
    .run_in(count_run),
    .load_in(cnt_load),
    .load_val_in(pwdata_in[WDG_W-1:0]),
    .count_out(watchdog_counter),
    .wrap_out(wrap)
  );

  always_comb begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    case (state)
      WDG_ST_RUN: begin
        if (wrap) begin
          next_state = WDG_ST_RESET;
          next_rst_cnt = RC_W'(RST_CYC - 1);
        end
      end
      WDG_ST_RESET: begin
        if (rst_cnt == '0) begin
          next_state = WDG_ST_RUN;
        end else begin
          next_rst_cnt = rst_cnt - RC_W'(1);
        end
      end
      default: begin
        next_state = WDG_ST_RUN;
        next_rst_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= WDG_ST_RUN;
      rst_cnt <= '0;
    end else begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
    end
  end

  // set by write or any reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_run <= `WDG_RST_RUN;
    end else if (sys_init) begin
      count_run <= `WDG_RST_RUN;
    end else if (run_wr) begin
      count_run <= pwdata_in[`WDG_BIT_RUN];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control_write_permit <= `WDG_RST_PERMIT;
      counter_write_permit <= `WDG_RST_PERMIT;
    end else if (sys_init) begin
      control_write_permit <= `WDG_RST_PERMIT;
      counter_write_permit <= `WDG_RST_PERMIT;
    end else begin
      if (cperm_wr) begin
        control_write_permit <= pwdata_in[`WDG_BIT_CPERMIT];
      end
      if (nperm_wr) begin
        counter_write_permit <= pwdata_in[`WDG_BIT_NPERMIT];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overflow_reset_flag <= `WDG_RST_FLAG;
    end else if (wrap) begin
      overflow_reset_flag <= 1'b1;
    end else if (pin_rst || (flag_clr && !sys_init)) begin
      overflow_reset_flag <= 1'b0;
    end
  end

  // Sticky events, write one to clear, set wins
  wire [`WDG_IRQ_W-1:0] irq_set = {pin_rst, wrap};
  wire [`WDG_IRQ_W-1:0] irq_clr = (wr && sel_stat) ? pwdata_in[`WDG_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr && sel_mask) begin
        irq_mask <= pwdata_in[`WDG_IRQ_W-1:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h00000000;
    end else if (setup && !pwrite_in) begin
      prdata_out <= rd_mux;
    end
  end

  run_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !count_run && !sys_init && !cnt_load |=> $stable(watchdog_counter))
    else $error("counter moved while stopped");

  run_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    run_wr && pwdata_in[`WDG_BIT_RUN] |=> count_run)
    else $error("run bit not set by write");

  // permitted guarded zero write stops counting
  run_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    run_wr && !pwdata_in[`WDG_BIT_RUN] && !sys_init |=> !count_run)
    else $error("run bit not cleared by write");

  // guard bits always read as one
  guard_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    access && !pwrite_in && sel_ctrl |->
      prdata_out[7] && prdata_out[5] && prdata_out[3] && prdata_out[1])
    else $error("guard bit read as zero");

  // overflow raises flag and reset pulse
  ovf_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wrap |=> overflow_reset_flag && wdg_reset_out)
    else $error("overflow did not record reset");

  pulse_len_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(wdg_reset_out) |->
      wdg_reset_out [*8] ##1 wdg_reset_out ##1 wdg_reset_out ##1 !wdg_reset_out)
    else $error("internal reset pulse length wrong");

  flag_clr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    flag_clr && !sys_init && !wrap |=> !overflow_reset_flag)
    else $error("flag not cleared by write");

  // watchdog reset keeps the flag, pin reset clears it
  flag_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wdg_rst_active && !pin_rst && overflow_reset_flag |=> overflow_reset_flag)
    else $error("watchdog reset cleared flag");

  pin_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    pin_rst && !wrap |=> !overflow_reset_flag)
    else $error("pin reset left flag set");

  // no permit, no change of run
  permit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_ctrl && !control_write_permit && !sys_init |=> $stable(count_run))
    else $error("run changed without permit");

  run_guard_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_ctrl && pwdata_in[`WDG_BIT_RUN_GUARD] && !sys_init |=> $stable(count_run))
    else $error("run changed with guard set");

  cnt_permit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_count && !counter_write_permit && !count_run && !sys_init |=>
      $stable(watchdog_counter))
    else $error("counter written without permit");

  wrap_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(wrap) |-> $past(&watchdog_counter) && (watchdog_counter == '0))
    else $error("wrap not from all ones");

  reset_run_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    sys_init |=> count_run)
    else $error("reset left run bit clear");

  permit_guard_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_ctrl && pwdata_in[`WDG_BIT_CPERMIT_GUARD] && !sys_init |=> $stable(control_write_permit))
    else $error("permit changed with guard set");

  cnt_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cnt_load |=> watchdog_counter == $past(pwdata_in[WDG_W-1:0]))
    else $error("counter not loaded by write");
endmodule
`default_nettype wire

//--- pkg/wdg_cfg.svh
// Constants of the guarded watchdog: register offsets, bit positions, reset values, timing.
// Assumes a 10 MHz system clock and an APB register window of 256 bytes.
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH

`define WDG_ADDR_W 8
`define WDG_OFS_CTRL 8'h00
`define WDG_OFS_COUNT 8'h04
`define WDG_OFS_IRQ_STAT 8'h08
`define WDG_OFS_IRQ_MASK 8'h0c

`define WDG_BIT_FLAG 0
`define WDG_BIT_FLAG_GUARD 1
`define WDG_BIT_RUN 2
`define WDG_BIT_RUN_GUARD 3
`define WDG_BIT_CPERMIT 4
`define WDG_BIT_CPERMIT_GUARD 5
`define WDG_BIT_NPERMIT 6
`define WDG_BIT_NPERMIT_GUARD 7

`define WDG_RST_RUN 1'b1
`define WDG_RST_PERMIT 1'b0
`define WDG_RST_FLAG 1'b0

`define WDG_IRQ_OVF 0
`define WDG_IRQ_PIN 1
`define WDG_IRQ_W 2

`define WDG_CLK_PERIOD_NS 100
`define WDG_RST_PULSE_NS 1000
`define WDG_RST_PULSE_CYC ((`WDG_RST_PULSE_NS + `WDG_CLK_PERIOD_NS - 1) / `WDG_CLK_PERIOD_NS)

`endif

//--- pkg/wdg_pkg.sv
// Types shared by the guarded watchdog modules.
// Assumes the constants of wdg_cfg.svh are included where numbers are needed.
package wdg_pkg;
  typedef enum logic [0:0] {
    WDG_ST_RUN = 1'b0,
    WDG_ST_RESET = 1'b1
  } wdg_rst_state_t;
endpackage

//--- core/wdg_sync2.sv
// Two-stage synchroniser for levels arriving from pins.
// Assumes the input is asynchronous to clk_sys_in.
`timescale 1ns/10ps
`default_nettype none
module wdg_sync2 #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta <= {W{RST_VAL}};
      sync_out <= {W{RST_VAL}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

//--- core/wdg_counter.sv
// Watchdog up-counter with its count-rate divider and wrap detection.
// Assumes hold, run and load come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module wdg_counter #(
  parameter int WDG_W = 8,
  parameter int PRESCALE = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic hold_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [WDG_W-1:0] load_val_in,
  output logic [WDG_W-1:0] count_out,
  output logic wrap_out
);
  localparam int DIV_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESCALE - 1);

  logic [DIV_W-1:0] div;
  wire tick = (div == DIV_LAST);
  wire at_top = &count_out;
  wire step = tick && run_in && !load_in;

  if (WDG_W < 1 || WDG_W > 31) begin : g_bad_width
    $error("wdg_counter: WDG_W must be 1 to 31");
  end
  if (PRESCALE < 1) begin : g_bad_prescale
    $error("wdg_counter: PRESCALE must be at least 1");
  end

  // Divider runs only while counting
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div <= '0;
    end else if (hold_in || !run_in || tick) begin
      div <= '0;
    end else begin
      div <= div + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= '0;
      wrap_out <= 1'b0;
    end else if (hold_in) begin
      count_out <= '0;
      wrap_out <= 1'b0;
    end else begin
      if (load_in) begin
        count_out <= load_val_in;
      end else if (step) begin
        count_out <= count_out + WDG_W'(1);
      end
      wrap_out <= step && at_top;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_watchdog_guarded_control.sv
// Self-checking bench for the guarded watchdog control block.
// Assumes wdg_pkg and wdg_cfg.svh are compiled first; APB is driven directly.
`timescale 1ns/10ps
`default_nettype none
`include "wdg_cfg.svh"
module tb_watchdog_guarded_control;
  logic clk_sys_in;
  logic rst_b_in;
  logic ext_reset_b_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [31:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic wdg_reset_out;
  logic irq_out;
  int n_fail;
  int checks;
  int cycles;
  logic [31:0] rd;
  logic [31:0] c0;
  logic err;

  wdg_guarded_ctrl #(.WDG_W(8), .PRESCALE(1)) uut (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ext_reset_b_in(ext_reset_b_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .wdg_reset_out(wdg_reset_out),
    .irq_out(irq_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      $display("[ERR] %0t ns: run did not finish in time", $time);
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {24'h0, a};
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) begin
      @(posedge clk_sys_in);
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge clk_sys_in);
    chk({31'h0, irq_out}, {31'h0, exp});
  endtask

  // Load near all ones, let it wrap, and time the internal reset pulse
  task automatic overflow();
    int n;
    apb(1'b1, `WDG_OFS_CTRL, 32'h54);
    apb(1'b1, `WDG_OFS_COUNT, 32'hfc);
    n = 0;
    while (wdg_reset_out !== 1'b1 && n < 40) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(32'(n < 40), 32'h1);
    n = 0;
    while (wdg_reset_out === 1'b1 && n < 40) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(32'(n), 32'(`WDG_RST_PULSE_CYC));
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    cycles = 0;
    rst_b_in = 1'b0;
    ext_reset_b_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 32'h0;
    pwdata_in = 32'h0;
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hae);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, `WDG_OFS_COUNT, 32'h0);
    c0 = rd;
    apb(1'b0, `WDG_OFS_COUNT, 32'h0);
    chk(rd, (c0 + 32'h3) & 32'hff);
    $display("Reset values and free counting done");
    apb(1'b1, `WDG_OFS_CTRL, 32'h0);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hae);
    apb(1'b1, `WDG_OFS_CTRL, 32'h10);
    apb(1'b1, `WDG_OFS_CTRL, 32'h18);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hbe);
    apb(1'b1, `WDG_OFS_CTRL, 32'h10);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hba);
    apb(1'b0, `WDG_OFS_COUNT, 32'h0);
    c0 = rd;
    apb(1'b1, `WDG_OFS_COUNT, 32'h55);
    apb(1'b0, `WDG_OFS_COUNT, 32'h0);
    chk(rd, c0);
    apb(1'b1, `WDG_OFS_CTRL, 32'h54);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hfe);
    $display("Guarded run and permit writes done");
    apb(1'b1, `WDG_OFS_IRQ_MASK, 32'h1);
    overflow();
    irq_chk(1'b1);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'haf);
    apb(1'b1, `WDG_OFS_CTRL, 32'h10);
    apb(1'b1, `WDG_OFS_CTRL, 32'h12);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hbb);
    apb(1'b1, `WDG_OFS_IRQ_MASK, 32'h0);
    irq_chk(1'b0);
    apb(1'b1, `WDG_OFS_IRQ_MASK, 32'h1);
    irq_chk(1'b1);
    apb(1'b1, `WDG_OFS_IRQ_STAT, 32'h1);
    irq_chk(1'b0);
    apb(1'b0, `WDG_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("Overflow, flag guard and interrupt done");
    ext_reset_b_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    ext_reset_b_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hae);
    apb(1'b0, `WDG_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    $display("Reset pin done");
    overflow();
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'haf);
    apb(1'b1, `WDG_OFS_CTRL, 32'h10);
    apb(1'b1, `WDG_OFS_CTRL, 32'h10);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hba);
    $display("Flag software clear done");
    apb(1'b1, 8'h10, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, `WDG_OFS_CTRL, 32'h0);
    chk(rd, 32'hba);
    $display("Unmapped access done");
    conclude();
  end
endmodule
`default_nettype wire
